/* core/adf_pkg.sv */
// constants, coefficient sets and types for the decimation filter stage
//
// Overview of operation
// - ratio code 000 decimates output by two
// - ratio code 001 decimates output by four
// - ratio 011 no decimation, user coefficients only
// - ratio 100 decimates by eight, user coefficients
// - tap parity: clear 24 taps, set 23
// - filter-on bit routes samples through filter, else bypass
// - source bit clear loads built-in coefficients at ratio codes 000 and 001
// - offset enable bit switches offset correction
// - control register bit layout, bit six zero
// - decimate-by-two band: low or high pass
// - decimate-by-four band 00 gives low pass
// - reset pin high turns serial pins parallel
// - serial clock pin selects gain/reference when parallel
package adf_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int SAMPLE_W   = 14;             // raw converter sample
    localparam int TAP_W      = SAMPLE_W + 1;   // offset-corrected sample
    localparam int OUT_W      = 16;             // output word
    localparam int COEF_W     = 12;             // signed coefficient
    localparam int COEF_FRAC  = 11;             // coefficient fraction bits
    localparam int TAPS       = 24;             // full filter length
    localparam int SUM_W      = TAP_W + COEF_W + 5;
    localparam int EST_SHIFT  = 10;             // offset loop time constant
    localparam int ACC_W      = TAP_W + EST_SHIFT;
    localparam int FIFO_DEPTH = 8;              // output buffer words

    // ------------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------------
    localparam int          FRAME_BITS = 16;     // address byte, data byte
    localparam logic [4:0]  FRAME_LAST = 5'h0F;  // index of last bit

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_FILT_CTRL = 8'h1B;  // filter_control
    localparam logic [7:0] REG_BAND_SEL  = 8'h1D;  // filter_band_select
    localparam logic [7:0] CTRL_RESET    = 8'h00;  // processing bypassed
    localparam logic [7:0] BAND_RESET    = 8'h00;
    localparam int CTRL_OFFS_BIT = 7;              // offset correction on
    localparam int CTRL_ZERO_BIT = 6;              // always zero
    localparam int CTRL_SRC_BIT  = 5;              // 1 = user coefficients
    localparam int CTRL_FILT_BIT = 4;              // filter enable
    localparam int CTRL_ODD_BIT  = 3;              // odd tap enable
    localparam int RATIO_MSB     = 2;              // ratio field 2..0
    localparam int BAND_MSB      = 1;              // band field 1..0

    // ------------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------------
    localparam logic [2:0] RATIO_DEC2  = 3'h0;
    localparam logic [2:0] RATIO_DEC4  = 3'h1;
    localparam logic [2:0] RATIO_NODEC = 3'h3;
    localparam logic [2:0] RATIO_DEC8  = 3'h4;
    localparam logic [1:0] BAND_LOW    = 2'h0;
    localparam logic [1:0] BAND_HIGH   = 2'h1;
    // last phase of the decimation counter per ratio
    localparam logic [2:0] LAST_DEC2   = 3'h1;
    localparam logic [2:0] LAST_DEC4   = 3'h3;
    localparam logic [2:0] LAST_DEC8   = 3'h7;
    localparam logic [2:0] LAST_NODEC  = 3'h0;

    typedef logic signed [COEF_W-1:0] adf_coef_t;

    // ------------------------------------------------------------------
    // built-in sets; high pass is the low pass with alternating signs
    // ------------------------------------------------------------------
    localparam adf_coef_t LP2_COEF [TAPS] = '{
        12'h000, 12'hFFC, 12'h000, 12'h00A, 12'h000, 12'hFEC,
        12'h000, 12'h028, 12'h000, 12'hFAC, 12'h000, 12'h266,
        12'h266, 12'h000, 12'hFAC, 12'h000, 12'h028, 12'h000,
        12'hFEC, 12'h000, 12'h00A, 12'h000, 12'hFFC, 12'h000};
    localparam adf_coef_t LP4_COEF [TAPS] = '{
        12'hFFE, 12'hFFA, 12'hFF6, 12'hFF8, 12'h002, 12'h014,
        12'h030, 12'h054, 12'h07A, 12'h09C, 12'h0B4, 12'h0C0,
        12'h0C0, 12'h0B4, 12'h09C, 12'h07A, 12'h054, 12'h030,
        12'h014, 12'h002, 12'hFF8, 12'hFF6, 12'hFFA, 12'hFFE};

endpackage : adf_pkg

/* core/adf_filter.sv */
// output buffer and digital decimation filter stage with serial setup
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// small synchronous fifo
// ----------------------------------------------------------------------
module adf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];      // storage words
    logic [PW-1:0]    wr_ptr;           // next write slot
    logic [PW-1:0]    rd_ptr;           // oldest word
    logic [PW:0]      fill;             // words held
    logic             push;
    logic             pop;

    assign in_ready_o  = (fill != (PW+1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    // storage write
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
            fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    fill_bound_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        fill <= (PW+1)'(DEPTH))
        else $error("fifo fill exceeds depth");
endmodule : adf_fifo

// ----------------------------------------------------------------------
// filter stage top
// ----------------------------------------------------------------------
module adf_filter
    import adf_pkg::*;
(
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    // configuration pins
    input  wire logic                      reset_pin_i,
    input  wire logic                      serial_clock_pin_i,
    input  wire logic                      serial_data_pin_i,
    input  wire logic                      serial_select_pin_i,
    // user coefficient set, tap 0 in low bits
    input  wire logic [TAPS*COEF_W-1:0]    user_coef_i,
    // converter samples
    input  wire logic                      sample_valid_i,
    output logic                           sample_ready_o,
    input  wire logic [SAMPLE_W-1:0]       sample_i,
    // filtered output
    output logic                           out_valid_o,
    input  wire logic                      out_ready_i,
    output logic [OUT_W-1:0]               out_data_o,
    // configuration state
    output logic [7:0]                     filter_control_o,
    output logic [7:0]                     filter_band_select_o,
    output logic                           parallel_mode_o,
    output logic                           gain_ref_sel_o,
    output logic                           out_format_sel_o,
    output logic                           parallel_data_o
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync;               // reset pin, two stages
    logic [1:0] sclk_sync;              // serial clock pin
    logic [1:0] serial_data_pin_sync;             // serial data pin
    logic [1:0] sel_sync;               // serial select pin
    logic       sclk_prev;              // last synced clock level
    logic       rst_pin;
    logic       sclk_fall;

    // two flops per pin, nothing reads the first stage
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync   <= 2'h0;
            sclk_sync  <= 2'h0;
            serial_data_pin_sync <= 2'h0;
            sel_sync   <= 2'h3;
            sclk_prev  <= 1'b0;
        end else begin
            rst_sync   <= {rst_sync[0], reset_pin_i};
            sclk_sync  <= {sclk_sync[0], serial_clock_pin_i};
            serial_data_pin_sync <= {serial_data_pin_sync[0], serial_data_pin_i};
            sel_sync   <= {sel_sync[0], serial_select_pin_i};
            sclk_prev  <= sclk_sync[1];
        end
    end

    assign rst_pin   = rst_sync[1];
    assign sclk_fall = sclk_prev && !sclk_sync[1];

    // ------------------------------------------------------------------
    // parallel pin control
    // ------------------------------------------------------------------
    // high reset pin makes the serial pins static controls
    assign parallel_mode_o  = rst_pin;
    assign gain_ref_sel_o   = rst_pin && sclk_sync[1];
    assign out_format_sel_o = rst_pin && sel_sync[1];
    assign parallel_data_o  = rst_pin && serial_data_pin_sync[1];

    // ------------------------------------------------------------------
    // serial configuration receiver
    // ------------------------------------------------------------------
    logic [FRAME_BITS-1:0] shift_reg;   // address then data, msb first
    logic [4:0]            bit_cnt;     // bits taken in this frame
    logic                  frame_done;  // count at last bit, next bit ends frame
    logic                  wr_stb;      // one-cycle register write
    logic [7:0]            wr_addr;
    logic [7:0]            wr_data;

    // bits shift in on falling serial clock while select is low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
            bit_cnt   <= '0;
        end else if (rst_pin || sel_sync[1]) begin
            bit_cnt   <= '0;
        end else if (sclk_fall) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_data_pin_sync[1]};
            bit_cnt   <= frame_done ? '0 : bit_cnt + 1'b1;
        end
    end

    assign frame_done = (bit_cnt == FRAME_LAST);

    // write strobe one cycle after the last bit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_stb <= 1'b0;
        end else begin
            wr_stb <= sclk_fall && frame_done && !rst_pin && !sel_sync[1];
        end
    end

    assign wr_addr = shift_reg[FRAME_BITS-1:8];
    assign wr_data = shift_reg[7:0];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0] filter_control;         // offset, source, enable, ratio
    logic [7:0] filter_band_select;     // passband in low two bits

    // reset pin high clears both; unmapped addresses are ignored
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filter_control     <= CTRL_RESET;
            filter_band_select <= BAND_RESET;
        end else if (rst_pin) begin
            filter_control     <= CTRL_RESET;
            filter_band_select <= BAND_RESET;
        end else if (wr_stb && wr_addr == REG_FILT_CTRL) begin
            filter_control <= wr_data;
            filter_control[CTRL_ZERO_BIT] <= 1'b0;
        end else if (wr_stb && wr_addr == REG_BAND_SEL) begin
            filter_band_select <= {6'h00, wr_data[BAND_MSB:0]};
        end
    end

    assign filter_control_o     = filter_control;
    assign filter_band_select_o = filter_band_select;

    // field views
    logic       offs_en;
    logic       user_src;
    logic       filt_en;
    logic       odd_taps;
    logic [2:0] ratio;
    logic [1:0] band;

    assign offs_en  = filter_control[CTRL_OFFS_BIT];
    assign user_src = filter_control[CTRL_SRC_BIT];
    assign filt_en  = filter_control[CTRL_FILT_BIT];
    assign odd_taps = filter_control[CTRL_ODD_BIT];
    assign ratio    = filter_control[RATIO_MSB:0];
    assign band     = filter_band_select[BAND_MSB:0];

    // ------------------------------------------------------------------
    // coefficient selection
    // ------------------------------------------------------------------
    adf_coef_t coef [TAPS];             // set applied to the taps
    logic      builtin_ok;              // ratio permits built-in sets

    assign builtin_ok = (ratio == RATIO_DEC2) || (ratio == RATIO_DEC4);

    // built-in unless user set chosen or ratio forbids it
    always_comb begin
        for (int k = 0; k < TAPS; k++) begin
            if (user_src || !builtin_ok) begin
                coef[k] = user_coef_i[k*COEF_W +: COEF_W];
            end else if (ratio == RATIO_DEC4) begin
                coef[k] = LP4_COEF[k];
            end else if (band == BAND_HIGH && k[0]) begin
                coef[k] = -LP2_COEF[k];
            end else begin
                coef[k] = LP2_COEF[k];
            end
        end
        if (odd_taps) begin
            coef[TAPS-1] = '0;
        end
    end

    // ------------------------------------------------------------------
    // offset correction
    // ------------------------------------------------------------------
    logic signed [ACC_W-1:0] est_acc;   // scaled offset estimate
    logic signed [TAP_W-1:0] est;
    logic signed [TAP_W-1:0] corrected;
    logic                    take;      // sample accepted this cycle

    assign est       = est_acc[ACC_W-1 -: TAP_W];
    assign corrected = TAP_W'(signed'(sample_i)) - est;
    assign take      = sample_valid_i && sample_ready_o;

    // leaky average of the input, cleared while disabled
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            est_acc <= '0;
        end else if (!offs_en) begin
            est_acc <= '0;
        end else if (take) begin
            est_acc <= est_acc + ACC_W'(corrected);
        end
    end

    // ------------------------------------------------------------------
    // tap line, decimation and output stage
    // ------------------------------------------------------------------
    logic signed [TAP_W-1:0] taps      [TAPS];  // newest at index 0
    logic signed [TAP_W-1:0] next_taps [TAPS];
    logic [2:0]              phase;             // decimation phase
    logic [2:0]              last_phase;
    logic                    ratio_ok;          // ratio code is defined
    logic                    emit;              // push a result
    logic                    stage_v;           // result waiting for fifo
    logic [OUT_W-1:0]        stage_d;
    logic                    fifo_ready;

    // multiply-accumulate over the whole tap line
    function automatic logic signed [SUM_W-1:0] fir_sum(
        input logic signed [TAP_W-1:0] t [TAPS],
        input adf_coef_t               c [TAPS]);
        logic signed [SUM_W-1:0]        s;
        logic signed [TAP_W+COEF_W-1:0] p;  // full-width product
        s = '0;
        for (int k = 0; k < TAPS; k++) begin
            p = t[k] * c[k];
            s = s + SUM_W'(p);
        end
        return s;
    endfunction : fir_sum

    // ratio code to last counter phase
    always_comb begin
        ratio_ok = 1'b1;
        unique case (ratio)
            RATIO_DEC2:  last_phase = LAST_DEC2;
            RATIO_DEC4:  last_phase = LAST_DEC4;
            RATIO_NODEC: last_phase = LAST_NODEC;
            RATIO_DEC8:  last_phase = LAST_DEC8;
            default: begin
                last_phase = LAST_NODEC;
                ratio_ok   = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_taps[0] = corrected;
        for (int k = 1; k < TAPS; k++) begin
            next_taps[k] = taps[k-1];
        end
    end

    // bypass passes every sample; filter emits on the last phase
    assign emit = take && (!filt_en || (ratio_ok && phase == last_phase));

    // tap line shifts on every accepted sample
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < TAPS; k++) taps[k] <= '0;
        end else if (take) begin
            taps <= next_taps;
        end
    end

    // decimation phase counter, restarts with the filter off
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= '0;
        end else if (!filt_en || !ratio_ok) begin
            phase <= '0;
        end else if (take) begin
            phase <= (phase == last_phase) ? '0 : phase + 1'b1;
        end
    end

    // result register ahead of the fifo
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage_v <= 1'b0;
            stage_d <= '0;
        end else begin
            if (stage_v && fifo_ready) stage_v <= 1'b0;
            if (emit) begin
                stage_v <= 1'b1;
                if (filt_en) begin
                    stage_d <= OUT_W'(fir_sum(next_taps, coef)
                               >>> COEF_FRAC);
                end else begin
                    stage_d <= OUT_W'(corrected);
                end
            end
        end
    end

    // source stalls while the result register cannot drain
    assign sample_ready_o = !stage_v || fifo_ready;

    adf_fifo #(
        .WIDTH (OUT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (stage_v),
        .in_ready_o  (fifo_ready),
        .in_data_i   (stage_d),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_data_o)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [3:0] since;                  // samples taken since last emit

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since <= '0;
        end else if (!filt_en || emit) begin
            since <= '0;
        end else if (take) begin
            since <= since + 1'b1;
        end
    end

    dec_two_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) emit && filt_en && ratio == RATIO_DEC2
        && $stable(filter_control) |-> since == 4'h1)
        else $error("decimate by two spacing wrong");
    dec_four_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) emit && filt_en && ratio == RATIO_DEC4
        && $stable(filter_control) |-> since == 4'h3)
        else $error("decimate by four spacing wrong");
    dec_eight_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) emit && filt_en && ratio == RATIO_DEC8
        && $stable(filter_control) |-> since == 4'h7)
        else $error("decimate by eight spacing wrong");
    no_dec_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        take && filt_en && ratio == RATIO_NODEC |=> stage_v)
        else $error("undecimated sample not emitted");
    bypass_path_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) take && !filt_en
        |=> stage_v && stage_d == OUT_W'($past(corrected)))
        else $error("bypass sample altered");
    ctrl_write_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) wr_stb && wr_addr == REG_FILT_CTRL && !rst_pin
        |=> filter_control == ($past(wr_data) & 8'hBF))
        else $error("control register write mismatch");
    offset_off_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) !offs_en ##1 !offs_en |-> est == '0)
        else $error("offset applied while disabled");
    par_quiet_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        rst_pin [*3] |-> !wr_stb && filter_control == CTRL_RESET)
        else $error("register written in parallel mode");
    odd_len_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) odd_taps |-> coef[TAPS-1] == '0)
        else $error("odd tap filter uses last coefficient");
    band_zero_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) filter_band_select[7:2] == 6'h00)
        else $error("band register upper bits set");
endmodule : adf_filter

`default_nettype wire

/* tb/adf_host.sv */
// host model driving the serial configuration pins
`timescale 1ns/1ps
`default_nettype none
module adf_host (
    // clock
    input  wire logic clock_i,
    // configuration pins
    output logic      reset_pin_o,
    output logic      sclk_o,
    output logic      serial_data_pin_o,
    output logic      select_n_o
);
    // idle: clock still, data pulled down, select pulled up
    initial begin
        reset_pin_o = 1'b0;
        sclk_o      = 1'b0;
        serial_data_pin_o     = 1'b0;
        select_n_o  = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : wait_n
    // one write, address then data, msb first, 4 clocks a phase
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] w;
        w = {a, d};
        select_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_data_pin_o = w[i];
            sclk_o = 1'b1;
            wait_n(4);
            sclk_o = 1'b0;
            wait_n(4);
        end
        select_n_o = 1'b1;
        serial_data_pin_o = 1'b0;
        wait_n(8);
    endtask : wr
    // high-going pulse initialises the registers
    task automatic init();
        reset_pin_o = 1'b1;
        wait_n(4);
        reset_pin_o = 1'b0;
        wait_n(4);
    endtask : init
    // pin held high: serial pins become static controls
    task automatic par(input logic g, input logic d, input logic s);
        reset_pin_o = 1'b1;
        sclk_o = g;
        serial_data_pin_o = d;
        select_n_o = s;
        wait_n(4);
    endtask : par
endmodule : adf_host
`default_nettype wire

/* tb/tb_adf_filter.sv */
// self-checking bench for the decimation filter stage
`timescale 1ns/1ps
`default_nettype none
module tb_adf_filter import adf_pkg::*;;
    logic clk, rst_n, rp, sc, sd, ss, sv, sr, ordy, ov, pm, g, f, p, byp;
    logic [TAPS*COEF_W-1:0] coef;
    logic [SAMPLE_W-1:0]    smp;
    logic [OUT_W-1:0]       od, q[$];
    logic [7:0]             fc, fb, cur;
    longint                 h[TAPS];
    logic [7:0]             ctls[9] = '{8'h00, 8'h10, 8'h11, 8'h30,
                                        8'h31, 8'h3B, 8'h34, 8'h3A, 8'h90};
    int                     failures, checks, outs, acc;
    adf_filter dut (.clock_i(clk), .rst_n_i(rst_n), .reset_pin_i(rp),
        .serial_clock_pin_i(sc), .serial_data_pin_i(sd),
        .serial_select_pin_i(ss), .user_coef_i(coef),
        .sample_valid_i(sv), .sample_ready_o(sr), .sample_i(smp),
        .out_valid_o(ov), .out_ready_i(ordy), .out_data_o(od),
        .filter_control_o(fc), .filter_band_select_o(fb),
        .parallel_mode_o(pm), .gain_ref_sel_o(g),
        .out_format_sel_o(f), .parallel_data_o(p));
    adf_host host (.clock_i(clk), .reset_pin_o(rp), .sclk_o(sc),
        .serial_data_pin_o(sd), .select_n_o(ss));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // inputs per output word for each ratio code
    function automatic int per(input logic [2:0] r);
        case (r)
            3'h0: return 2;
            3'h1: return 4;
            3'h3: return 1;
            3'h4: return 8;
            default: return 0;
        endcase
    endfunction : per
    // coefficient the filter should apply to tap k under control c
    function automatic longint cf(input logic [7:0] c, input int k);
        if (c[3] && k == TAPS-1) return 0;
        if (c[5] || c[2:0] > 3'h1)
            return adf_coef_t'(coef[k*COEF_W +: COEF_W]);
        if (c[0]) return LP4_COEF[k];
        return LP2_COEF[k];
    endfunction : cf
    // expected filtered word from the sample history, newest first
    function automatic logic [OUT_W-1:0] fir(input logic [7:0] c);
        longint s;
        s = 0;
        for (int k = 0; k < TAPS; k++) s += h[k] * cf(c, k);
        return OUT_W'(s >>> COEF_FRAC);
    endfunction : fir
    // accepted samples and drained words
    always @(posedge clk) begin
        if (sv && sr) begin
            acc++;
            for (int k = TAPS-1; k > 0; k--) h[k] = h[k-1];
            h[0] = longint'(signed'(smp));
            if (byp) q.push_back(OUT_W'(signed'(smp)));
            else if (per(cur[2:0]) > 0 && acc % per(cur[2:0]) == 0)
                q.push_back(fir(cur));
        end
        if (ov && ordy) begin
            outs++;
            if (!cur[7])
                chk(q.size() > 0 && od === q[0], "data");
            if (q.size() > 0) void'(q.pop_front());
        end
    end
    // fresh start, one setting, n samples with a stalling drain
    task automatic run(input logic [7:0] c, input int n);
        int e, k;
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        host.wr(8'h1B, c);
        byp = !c[4];
        cur = c;
        q.delete();
        foreach (h[i]) h[i] = 0;
        outs = 0;
        acc = 0;
        sv = 1'b1;
        while (acc < n) begin
            k = acc;
            @(posedge clk);
            #1;
            if (acc != k) smp = SAMPLE_W'($urandom);
            ordy = 1'($urandom);
        end
        sv = 1'b0;
        ordy = 1'b1;
        repeat (30) @(posedge clk);
        #1;
        e = per(c[2:0]);
        chk(outs === (byp ? n : (e > 0 ? n / e : 0)), "count");
        $display("test ratio %h done", c);
    endtask : run
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        {failures, checks, outs, acc} = '0;
        {rst_n, sv, smp, byp, ordy} = '0;
        void'($urandom(65546));
        for (int i = 0; i < 9; i++) coef[32*i +: 32] = $urandom;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        host.init();
        host.wr(8'h1B, 8'hFF);
        chk(fc === 8'hBF, "control");
        host.wr(8'h1D, 8'hFF);
        chk(fb === 8'h03, "band");
        host.wr(8'h33, 8'h00);
        chk(fc === 8'hBF, "unmapped");
        host.init();
        chk(fc === 8'h00, "init");
        $display("test registers done");
        foreach (ctls[i]) run(ctls[i], 32);
        run(8'h00, 0);
        ordy = 1'b0;
        sv = 1'b1;
        repeat (15) @(posedge clk);
        #1;
        chk(acc === 9 && sr === 1'b0, "fill");
        sv = 1'b0;
        ordy = 1'b1;
        repeat (15) @(posedge clk);
        #1;
        chk(ov === 1'b0 && outs === 9, "drain");
        $display("test buffer done");
        host.par(1'b1, 1'b0, 1'b1);
        chk({pm, g, p, f} === 4'hD, "parallel");
        $display("test parallel done");
        report_and_stop();
    end
endmodule : tb_adf_filter
`default_nettype wire
